// ===== dv/eeprom_dev_model.sv
// behavioural memory device with page load, protection and identifier
`timescale 1ns/1ns
module eeprom_dev_model
  import eeprom_host_pkg::*;
#(
  parameter int unsigned WIN_NS = 4000,
  parameter logic [7:0]  MAKER  = 8'h80,  // arbitrary value
  parameter logic [7:0]  PART   = 8'h83   // arbitrary value
) (
  // memory pins
  input  wire logic [ADDR_W-1:0] MEM_A,
  input  wire logic              MEM_ID_HV,
  input  wire logic [7:0]        MEM_D_OUT,
  input  wire logic              MEM_CE_N,
  input  wire logic              MEM_OE_N,
  input  wire logic              MEM_WE_N,
  output logic [7:0]             MEM_D_IN
);
  logic [7:0]  mem [int];
  logic        prot = 1'b0;
  logic        act  = 1'b0;
  logic [14:0] lat_a;
  logic [14:0] qa [$];
  logic [7:0]  qd [$];
  logic [7:0]  junk = 8'h5A;
  logic        supply_ok = 1'b1;
  time         t_fall;
  time         t_rise;
  // released bus keeps toggling so a stale byte never passes
  always #40 junk = ~junk;
  assign MEM_D_IN = (!MEM_CE_N && !MEM_OE_N && MEM_ID_HV) ? (MEM_A[0] ? PART : MAKER) : junk;
  always @(negedge MEM_WE_N or negedge MEM_CE_N)
    if (!MEM_WE_N && !MEM_CE_N && MEM_OE_N && supply_ok) begin
      act = 1'b1;
      lat_a = MEM_A;
      t_fall = $time;
    end
  always @(posedge MEM_WE_N or posedge MEM_CE_N)
    if (act) begin
      act = 1'b0;
      if ($time - t_fall >= 20) begin
        qa.push_back(lat_a);
        qd.push_back(MEM_D_OUT);
        t_rise = $time;
      end
    end
  function automatic bit is_step(int i, logic [14:0] a, logic [7:0] d);
    return qa.size() > i && qa[i] === a && qd[i] === d;
  endfunction
  task automatic commit();
    int          first;
    bit          unl;
    logic [14:0] pa;
    first = 0;
    pa = qa[qa.size() - 1];
    unl = is_step(0, CMD_ADDR_A, CMD_AA) && is_step(1, CMD_ADDR_B, CMD_55);
    if (unl && is_step(2, CMD_ADDR_A, CMD_SET)) begin
      if (qa.size() == 3) prot = 1'b1;
      first = 3;
    end else if (unl && qa.size() == 6 && is_step(2, CMD_ADDR_A, CMD_CLR)
                 && is_step(3, CMD_ADDR_A, CMD_AA) && is_step(4, CMD_ADDR_B, CMD_55)
                 && is_step(5, CMD_ADDR_A, CMD_OFF)) begin
      prot = 1'b0;
      return;
    end else if (prot) begin
      return;
    end
    for (int i = first; i < qa.size(); i++) begin
      mem[{pa[14:6], qa[i][5:0]}] = 8'hFF;
      mem[{pa[14:6], qa[i][5:0]}] = qd[i];
    end
  endtask
  // window shortened so the run stays short; host waits longer than it
  always begin
    #100;
    if (qa.size() > 0 && !act && $time - t_rise >= WIN_NS) begin
      commit();
      qa.delete();
      qd.delete();
    end
  end
endmodule // eeprom_dev_model

// ===== dv/eeprom_host_bench.sv
// self-checking bench for the memory host controller
`timescale 1ns/1ns
module eeprom_host_bench
  import eeprom_host_pkg::*;
;
  localparam logic [7:0] MK = 8'h80; // arbitrary value
  localparam logic [7:0] PT = 8'h83; // arbitrary value
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_valid = 1'b0;
  logic        load_valid = 1'b0;
  cmd_s        cmd = '0;
  load_s       load = '0;
  wire logic   cmd_ready, load_ready, done, id_ok, id_match, id_hv, d_oe_n, ce_n, oe_n, we_n;
  wire logic [7:0]  id_byte, d_in, d_out;
  wire logic [14:0] addr;
  int          n_fail = 0;
  int          total_checks = 0;
  int          seed = 91845;
  logic [7:0]  shadow [int];
  logic [5:0]  ofs_q [64];
  logic [7:0]  dat_q [64];
  eeprom_host #(.WAIT_CYCLES(200), .MAKER_CODE(MK), .PART_CODE(PT)) dut (
    .CLK_SYS(clk), .RST_N(rst_n), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD(cmd),
    .LOAD_VALID(load_valid), .LOAD_READY(load_ready), .LOAD(load), .DONE(done),
    .ID_BYTE(id_byte), .ID_OK(id_ok), .ID_MATCH(id_match), .MEM_A(addr), .MEM_ID_HV(id_hv),
    .MEM_D_IN(d_in), .MEM_D_OUT(d_out), .MEM_D_OE_N(d_oe_n), .MEM_CE_N(ce_n),
    .MEM_OE_N(oe_n), .MEM_WE_N(we_n));
  eeprom_dev_model #(.MAKER(MK), .PART(PT)) dev (.MEM_A(addr), .MEM_ID_HV(id_hv),
    .MEM_D_OUT(d_out), .MEM_CE_N(ce_n), .MEM_OE_N(oe_n), .MEM_WE_N(we_n), .MEM_D_IN(d_in));
  initial forever #20 clk = ~clk;
  task automatic close_out();
    if (n_fail == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic run(input op_e op, input logic pr, input logic sel, input logic [8:0] pg,
                     input int n);
    int k;
    cmd_valid <= 1'b1;
    cmd <= '{op: op, prot: pr, id_sel: sel, page: pg, count: 7'(n)};
    @(posedge clk);
    while (cmd_ready !== 1'b1) @(posedge clk);
    cmd_valid <= 1'b0;
    for (k = 0; k < n && op == OP_WRITE; k++) begin
      load_valid <= 1'b1;
      load <= '{ofs: ofs_q[k], data: dat_q[k]};
      @(posedge clk);
      while (load_ready !== 1'b1) @(posedge clk);
    end
    load_valid <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    chk_bit(done, 1'b1);
  endtask
  // odd stride walks a permutation of the page, so load order is scrambled
  task automatic page_write(input logic pr, input logic [8:0] pg, input int n, input bit upd);
    int s;
    int st;
    s = $random(seed);
    st = ($random(seed) & 62) | 1;
    for (int k = 0; k < n; k++) begin
      ofs_q[k] = 6'(s + k * st);
      dat_q[k] = 8'($random(seed));
      if (upd) shadow[{pg, ofs_q[k]}] = dat_q[k];
    end
    run(OP_WRITE, pr, 1'b0, pg, n);
  endtask
  task automatic chk_page(input logic [8:0] pg);
    for (int i = 0; i < 64; i++)
      if (shadow.exists({pg, 6'(i)})) chk_byte(dev.mem[{pg, 6'(i)}], shadow[{pg, 6'(i)}]);
      else chk_bit(1'(dev.mem.exists({pg, 6'(i)})), 1'b0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    for (int i = 0; i < 2; i++) begin
      run(OP_READ_ID, 1'b0, 1'(i), 9'h000, 1);
      chk_byte(id_byte, i ? PT : MK);
      chk_bit(id_ok, 1'b1);
      chk_bit(id_match, 1'b1);
    end
    chk_bit(dev.prot, 1'b0);
    page_write(1'b0, 9'h011, 1, 1'b1);
    chk_page(9'h011);
    page_write(1'b0, 9'h012, 64, 1'b1);
    page_write(1'b0, 9'h012, 5, 1'b1);
    chk_page(9'h012);
    run(OP_PROT_ON, 1'b0, 1'b0, 9'h000, 1);
    chk_bit(dev.prot, 1'b1);
    page_write(1'b0, 9'h013, 2, 1'b0);
    chk_page(9'h013);
    page_write(1'b1, 9'h013, 64, 1'b1);
    page_write(1'b1, 9'h013, 3, 1'b1);
    chk_page(9'h013);
    chk_bit(1'(dev.mem.exists(15'h5555)), 1'b0);
    run(OP_PROT_OFF, 1'b0, 1'b0, 9'h000, 1);
    chk_bit(dev.prot, 1'b0);
    for (int i = 0; i < 6; i++) begin
      automatic logic [8:0] pg = 9'h100 | 9'($random(seed) & 63);
      page_write(1'b0, pg, 1 + ($random(seed) & 63), 1'b1);
      chk_page(pg);
    end
    close_out();
  end
  initial begin
    #(40 * 70000);
    n_fail++;
    close_out();
  end
endmodule // eeprom_host_bench

// ===== dv/eeprom_host_properties.sv
// pin timing checks for the memory host controller
`timescale 1ns/1ns
module eeprom_host_properties
  import eeprom_host_pkg::*;
(
  // clock and reset
  input wire logic              CLK_SYS,
  input wire logic              RST_N,
  // identifier result
  input wire logic [7:0]        ID_BYTE,
  input wire logic              ID_OK,
  // memory pins
  input wire logic [ADDR_W-1:0] MEM_A,
  input wire logic              MEM_ID_HV,
  input wire logic [7:0]        MEM_D_OUT,
  input wire logic              MEM_D_OE_N,
  input wire logic              MEM_CE_N,
  input wire logic              MEM_OE_N,
  input wire logic              MEM_WE_N
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  sequence low_pulse;
    !MEM_WE_N [*4] ##1 MEM_WE_N;
  endsequence
  sequence hold_phase;
    (!MEM_CE_N && $stable(MEM_A)) [*8];
  endsequence
  a_gate_blocks_write: assert property (!MEM_WE_N |-> MEM_OE_N && !MEM_CE_N)
    else $error("write strobe low without select or with gate low");
  a_data_driven: assert property (!MEM_WE_N |-> !MEM_D_OE_N)
    else $error("write strobe low while data released");
  a_pulse_width: assert property ($fell(MEM_WE_N) |-> low_pulse)
    else $error("write pulse not four cycles");
  a_select_first: assert property ($fell(MEM_WE_N) |-> !$past(MEM_CE_N, 2) && !$past(MEM_D_OE_N, 2))
    else $error("select or data not set up before strobe");
  a_pins_steady: assert property (!MEM_WE_N && !$fell(MEM_WE_N) |-> $stable(MEM_A) && $stable(MEM_D_OUT))
    else $error("address or data moved during strobe");
  a_hold_after: assert property ($rose(MEM_WE_N) |-> hold_phase)
    else $error("select or address not held after strobe");
  a_id_no_write: assert property (MEM_ID_HV && !MEM_CE_N |-> MEM_WE_N && MEM_D_OE_N && MEM_A[14:1] == 14'h0)
    else $error("identifier read with bad pins");
  a_id_parity: assert property (ID_OK == ^ID_BYTE)
    else $error("parity flag disagrees with byte");
endmodule // eeprom_host_properties

bind eeprom_host eeprom_host_properties chk (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
  .ID_BYTE(ID_BYTE), .ID_OK(ID_OK), .MEM_A(MEM_A), .MEM_ID_HV(MEM_ID_HV),
  .MEM_D_OUT(MEM_D_OUT), .MEM_D_OE_N(MEM_D_OE_N), .MEM_CE_N(MEM_CE_N),
  .MEM_OE_N(MEM_OE_N), .MEM_WE_N(MEM_WE_N));

// ===== rtl/eeprom_host.sv
// host controller driving the parallel memory write, protection and id sequences
`timescale 1ns/1ns
module eeprom_host
  import eeprom_host_pkg::*;
#(
  parameter int unsigned WAIT_CYCLES = WAIT_CYC,
  parameter logic [7:0]  MAKER_CODE  = 8'h80,  // arbitrary value
  parameter logic [7:0]  PART_CODE   = 8'h83   // arbitrary value
) (
  // clock and reset
  input  wire logic               CLK_SYS,
  input  wire logic               RST_N,
  // command side
  input  wire logic               CMD_VALID,
  output logic                    CMD_READY,
  input  cmd_s                    CMD,
  input  wire logic               LOAD_VALID,
  output logic                    LOAD_READY,
  input  load_s                   LOAD,
  output logic                    DONE,
  output logic [7:0]              ID_BYTE,
  output logic                    ID_OK,
  output logic                    ID_MATCH,
  // memory pins
  output logic [ADDR_W-1:0]       MEM_A,
  output logic                    MEM_ID_HV,
  input  wire logic [7:0]         MEM_D_IN,
  output logic [7:0]              MEM_D_OUT,
  output logic                    MEM_D_OE_N,
  output logic                    MEM_CE_N,
  output logic                    MEM_OE_N,
  output logic                    MEM_WE_N
);

  typedef enum logic [2:0] {
    H_IDLE, H_SEQ, H_LOAD, H_WAIT, H_ID, H_END
  } hst_e;

  logic        rst_s1_q;
  logic        rst_n_q;
  hst_e        st_q;
  cmd_s        cmd_q;
  logic [2:0]  step_q;
  logic [6:0]  left_q;
  logic [31:0] tmr_q;
  logic        sgo;
  logic [14:0] saddr;
  logic [7:0]  sdata;
  logic        sbusy;
  logic        sdone;
  logic [14:0] sa;
  logic [7:0]  sd;
  logic        sdoe_n;
  logic        swe_n;
  logic        sce_n;
  logic        id_ce_n_q;
  logic        id_oe_n_q;
  logic [2:0]  nseq;
  logic [7:0]  expect_id;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // the fixed command prefixes, indexed by step
  function automatic logic [22:0] seq_word(input op_e op, input logic [2:0] s);
    logic [7:0] last;
    last = (op == OP_PROT_OFF) ? CMD_CLR : CMD_SET;
    case (s)
      3'd0, 3'd3: seq_word = {CMD_ADDR_A, CMD_AA};
      3'd1, 3'd4: seq_word = {CMD_ADDR_B, CMD_55};
      3'd2:       seq_word = {CMD_ADDR_A, last};
      default:    seq_word = {CMD_ADDR_A, CMD_OFF};
    endcase
  endfunction

  always_comb begin
    case (cmd_q.op)
      OP_PROT_OFF: nseq = 3'd6;
      OP_PROT_ON:  nseq = 3'd3;
      default:     nseq = cmd_q.prot ? 3'd3 : 3'd0;
    endcase
  end

  assign CMD_READY  = (st_q == H_IDLE);
  // loads go out only between strobes, so gaps stay far below the window
  // ready does not wait on valid, so the handshake can complete;
  // masked on the last done so no extra byte slips into the page
  assign LOAD_READY = (st_q == H_LOAD) && !sbusy && !(sdone && left_q == 7'd1);
  assign sgo = ((st_q == H_SEQ) && !sbusy && !sdone) ||
               (LOAD_VALID && LOAD_READY);
  assign {saddr, sdata} = (st_q == H_SEQ) ? seq_word(cmd_q.op, step_q) :
                          {cmd_q.page, LOAD.ofs, LOAD.data};

  eeprom_strobe u_strobe (
    .clk      (CLK_SYS),
    .rst_n    (rst_n_q),
    .go       (sgo),
    .addr     (saddr),
    .data     (sdata),
    .busy     (sbusy),
    .done     (sdone),
    .a_q      (sa),
    .d_q      (sd),
    .d_oe_n_q (sdoe_n),
    .we_n_q   (swe_n),
    .ce_n_q   (sce_n)
  );

  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q   <= H_IDLE;
      cmd_q  <= '0;
      step_q <= 3'd0;
      left_q <= 7'd0;
      tmr_q  <= 32'd0;
      DONE   <= 1'b0;
    end else begin
      DONE <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (CMD_VALID) begin
            cmd_q  <= CMD;
            step_q <= 3'd0;
            tmr_q  <= 32'd0;
            // 1..64 bytes; zero is bumped to one
            left_q <= (CMD.count == 7'd0) ? 7'd1 :
                      (CMD.count > 7'(PAGE_BYTES)) ? 7'(PAGE_BYTES) : CMD.count;
            if (CMD.op == OP_READ_ID) begin
              st_q <= H_ID;
            end else if (CMD.op == OP_WRITE && !CMD.prot) begin
              st_q <= H_LOAD;
            end else begin
              st_q <= H_SEQ;
            end
          end
        end
        H_SEQ: begin
          // back-to-back strobes keep the sequence inside its timer
          if (sdone) begin
            step_q <= step_q + 3'd1;
            if (step_q + 3'd1 == nseq) begin
              st_q <= (cmd_q.op == OP_WRITE) ? H_LOAD : H_WAIT;
            end
          end
        end
        H_LOAD: begin
          if (sdone) begin
            left_q <= left_q - 7'd1;
            if (left_q == 7'd1) begin
              st_q  <= H_WAIT;
              tmr_q <= 32'd0;
            end
          end
        end
        H_WAIT: begin
          // strobe idle past the longest window plus the write time
          tmr_q <= tmr_q + 32'd1;
          if (tmr_q + 32'd1 >= WAIT_CYCLES) begin
            st_q <= H_END;
          end
        end
        H_ID: begin
          tmr_q <= tmr_q + 32'd1;
          if (tmr_q + 32'd1 >= 32'(READ_CYC)) begin
            st_q <= H_END;
          end
        end
        default: begin
          DONE <= 1'b1;
          st_q <= H_IDLE;
        end
      endcase
    end
  end

  // identifier read: high voltage on the id pin, gate low, strobe high
  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      MEM_ID_HV <= 1'b0;
      id_ce_n_q <= 1'b1;
      id_oe_n_q <= 1'b1;
    end else begin
      MEM_ID_HV <= (st_q == H_ID);
      id_ce_n_q <= (st_q != H_ID);
      id_oe_n_q <= (st_q != H_ID);
    end
  end

  assign expect_id = cmd_q.id_sel ? PART_CODE : MAKER_CODE;

  always_ff @(posedge CLK_SYS or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ID_BYTE  <= 8'h00;
      ID_OK    <= 1'b0;
      ID_MATCH <= 1'b0;
    end else if (st_q == H_ID && tmr_q + 32'd1 >= 32'(READ_CYC)) begin
      ID_BYTE  <= MEM_D_IN;
      ID_OK    <= odd_parity_ok(MEM_D_IN);
      ID_MATCH <= (MEM_D_IN == expect_id);
    end
  end

  // other addresses held low in id mode, low address bit picks the byte
  // held until select and gate are back up, so no stray address shows under 12 V
  assign MEM_A      = (st_q == H_ID || !id_ce_n_q) ? {14'h0000, cmd_q.id_sel} : sa;
  assign MEM_D_OUT  = sd;
  assign MEM_D_OE_N = sdoe_n;
  assign MEM_CE_N   = sce_n & id_ce_n_q;
  // gate held high through every write so none is inhibited
  assign MEM_OE_N   = id_oe_n_q;
  assign MEM_WE_N   = swe_n;

endmodule // eeprom_host

// ===== rtl/eeprom_host_pkg.sv
// constants and types shared by the memory write host controller
//
// Overview of operation
// - enable protection with 5555/AA, 2AAA/55, 5555/A0 in page timing
// - protected write sends three unlock bytes then data bytes as steps 4-67
// - host keeps page address bits steady during a whole page load
// - disable protection with six writes ending 5555/20
// - 12 V on id select pin reads maker byte or part byte by id byte select
package eeprom_host_pkg;

  localparam int unsigned CLK_MHZ        = 25;
  localparam int unsigned ADDR_W         = 15;
  localparam int unsigned PAGE_BYTES     = 64;
  localparam int unsigned PAGE_OFS_W     = 6;

  // strobe shape, in ns
  localparam int unsigned SETUP_NS       = 80;
  localparam int unsigned PULSE_NS       = 150;
  localparam int unsigned HOLD_NS        = 1000;
  localparam int unsigned SETUP_CYC      = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned PULSE_CYC      = (PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned HOLD_CYC       = (HOLD_NS * CLK_MHZ + 999) / 1000;

  // page window and write time, in us
  localparam int unsigned WINDOW_MIN_US  = 100;
  localparam int unsigned WINDOW_MAX_US  = 1000;
  localparam int unsigned WRITE_US       = 12000;
  localparam int unsigned GAP_MAX_CYC    = WINDOW_MIN_US * CLK_MHZ / 2;
  localparam int unsigned WAIT_CYC       = (WINDOW_MAX_US + WRITE_US) * CLK_MHZ;
  localparam int unsigned READ_CYC       = 8;

  localparam logic [14:0] CMD_ADDR_A     = 15'h5555;
  localparam logic [14:0] CMD_ADDR_B     = 15'h2AAA;
  localparam logic [7:0]  CMD_AA         = 8'hAA;
  localparam logic [7:0]  CMD_55         = 8'h55;
  localparam logic [7:0]  CMD_SET        = 8'hA0;
  localparam logic [7:0]  CMD_CLR        = 8'h80;
  localparam logic [7:0]  CMD_OFF        = 8'h20;

  typedef enum logic [2:0] {
    OP_WRITE   = 3'h0,
    OP_PROT_ON = 3'h1,
    OP_PROT_OFF= 3'h2,
    OP_READ_ID = 3'h3
  } op_e;

  typedef struct packed {
    op_e          op;
    logic         prot;     // device currently protected
    logic         id_sel;   // which identifier byte
    logic [8:0]   page;
    logic [6:0]   count;    // bytes to load, 1..64
  } cmd_s;

  typedef struct packed {
    logic [PAGE_OFS_W-1:0] ofs;
    logic [7:0]            data;
  } load_s;

  function automatic logic odd_parity_ok(input logic [7:0] b);
    return ^b;
  endfunction

endpackage : eeprom_host_pkg

// ===== rtl/eeprom_strobe.sv
// one write strobe on the memory pins with setup, pulse and hold spacing
`timescale 1ns/1ns
module eeprom_strobe
  import eeprom_host_pkg::*;
(
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // request
  input  wire logic               go,
  input  wire logic [ADDR_W-1:0]  addr,
  input  wire logic [7:0]         data,
  output logic                    busy,
  output logic                    done,
  // pins
  output logic [ADDR_W-1:0]       a_q,
  output logic [7:0]              d_q,
  output logic                    d_oe_n_q,
  output logic                    we_n_q,
  output logic                    ce_n_q
);

  typedef enum logic [1:0] {S_IDLE, S_SETUP, S_PULSE, S_HOLD} st_e;
  st_e        st_q;
  logic [7:0] cnt_q;

  assign busy = (st_q != S_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q     <= S_IDLE;
      cnt_q    <= 8'h00;
      a_q      <= '0;
      d_q      <= 8'h00;
      d_oe_n_q <= 1'b1;
      we_n_q   <= 1'b1;
      ce_n_q   <= 1'b1;
      done     <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (go) begin
            // select falls first so the strobe is the lagging edge
            a_q      <= addr;
            d_q      <= data;
            d_oe_n_q <= 1'b0;
            ce_n_q   <= 1'b0;
            cnt_q    <= 8'(SETUP_CYC);
            st_q     <= S_SETUP;
          end
        end
        S_SETUP: begin
          if (cnt_q <= 8'h01) begin
            we_n_q <= 1'b0;
            cnt_q  <= 8'(PULSE_CYC);
            st_q   <= S_PULSE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        S_PULSE: begin
          // pulse well over 20 ns so the lockout never eats it
          if (cnt_q <= 8'h01) begin
            we_n_q <= 1'b1;
            cnt_q  <= 8'(HOLD_CYC);
            st_q   <= S_HOLD;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
        default: begin
          if (cnt_q == 8'h02) begin
            ce_n_q   <= 1'b1;
            d_oe_n_q <= 1'b1;
          end
          if (cnt_q <= 8'h01) begin
            done <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            cnt_q <= cnt_q - 8'h01;
          end
        end
      endcase
    end
  end

endmodule // eeprom_strobe
